// File: rtl/lcd_twi_pkg.sv
// shared constants and types of the two-wire display command port
package lcd_twi_pkg;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int SPIKE_NS      = 50;
	// a pulse must outlast the longest spike before it counts
	localparam int FILT_CYC      = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	// ==========================================================
	// addressing and control byte layout
	localparam logic [4:0] ADDR_BASE  = 5'h0F;
	localparam int         CO_BIT     = 7;
	localparam int         SEL_BIT    = 6;
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam int         PTR_W      = 10;
	localparam logic [9:0] PTR_RST    = 10'h000;
	localparam logic       SEL_RST    = 1'h0;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_IGNORE
	} state_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} cmd_s;

	typedef struct packed {
		logic             valid;
		logic [PTR_W-1:0] addr;
		logic [7:0]       data;
	} ram_wr_s;
endpackage

// File: rtl/lcd_twi_port.sv
// two-wire slave port: address match, control/data parsing, ram and command output
// Operation
// - idle bus rests high, lines released
// - sda fall with scl high starts
// - sda rise with scl high stops
// - one bit per scl pulse, stable high
// - ninth clock of each byte is acknowledge
// - receiver acknowledges by holding sda low
// - four addresses chosen by two select pins
// - foreign address: ignore transfer, no acknowledge
// - control byte then data byte per word
// - continuation clear: only data bytes follow
// - continuation set: control byte after data
// - select one: write ram, advance pointer
// - select zero: byte to command decoder
// - read with last select zero sends data
// - master nack stops sending, releases sda
// - after nack leave sda high
// - reject line spikes up to 50 ns
// - pointer steps one column per byte
`timescale 1ns/1ps
module lcd_twi_port (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_scl,
	input  wire logic                   i_sda,
	output logic                        o_sda_o,
	output logic                        o_sda_oe,
	input  wire logic                   i_addr_select_lo,
	input  wire logic                   i_addr_select_hi,
	input  wire logic                   i_ptr_load,
	input  wire logic [lcd_twi_pkg::PTR_W-1:0] i_ptr_value,
	input  wire logic [7:0]             i_rd_data,
	output lcd_twi_pkg::cmd_s           o_cmd,
	output lcd_twi_pkg::ram_wr_s        o_ram_wr,
	output logic                        o_busy
);
	// ==========================================================
	// link clock domain: sample sda on each scl rise
	logic link_bit_q;
	logic link_bit_d;

	always_comb begin
		link_bit_d = i_sda;
	end

	always_ff @(posedge i_scl or posedge i_rst) begin
		if (i_rst) begin
			link_bit_q <= 1'b1;
		end else begin
			link_bit_q <= link_bit_d;
		end
	end

	// ==========================================================
	// crossings into the core clock
	// the sampled bit holds for a full scl period, so a level sync is enough
	logic bit_meta_q;
	logic bit_sync_q;
	logic sel_meta_q;
	logic sel_sync_q;
	logic [1:0] as_meta_q;
	logic [1:0] as_sync_q;
	logic scl_f;
	logic sda_f;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			bit_meta_q <= 1'b1;
			bit_sync_q <= 1'b1;
			as_meta_q  <= 2'h0;
			as_sync_q  <= 2'h0;
			sel_meta_q <= 1'b0;
			sel_sync_q <= 1'b0;
		end else begin
			bit_meta_q <= link_bit_q;
			bit_sync_q <= bit_meta_q;
			as_meta_q  <= {i_addr_select_hi, i_addr_select_lo};
			as_sync_q  <= as_meta_q;
			sel_meta_q <= 1'b0;
			sel_sync_q <= sel_meta_q;
		end
	end

	line_filter #(
		.STABLE_CYC (lcd_twi_pkg::FILT_CYC),
		.RST_VAL    (1'b1)
	) u_scl_filt (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_line     (i_scl),
		.o_line     (scl_f)
	);

	line_filter #(
		.STABLE_CYC (lcd_twi_pkg::FILT_CYC),
		.RST_VAL    (1'b1)
	) u_sda_filt (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_line     (i_sda),
		.o_line     (sda_f)
	);

	// ==========================================================
	// bus conditions
	logic scl_p_q;
	logic sda_p_q;
	logic start_ev;
	logic stop_ev;
	logic rise_ev;
	logic fall_ev;
	logic [6:0] own_addr;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
		end
	end

	assign start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
	assign stop_ev  = scl_f & scl_p_q & ~sda_p_q & sda_f;
	assign rise_ev  = scl_f & ~scl_p_q;
	assign fall_ev  = ~scl_f & scl_p_q;
	assign own_addr = {lcd_twi_pkg::ADDR_BASE, as_sync_q};

	// ==========================================================
	// protocol state
	lcd_twi_pkg::state_e st_q;
	lcd_twi_pkg::state_e st_d;
	logic [7:0]          sh_q;
	logic [7:0]          sh_d;
	logic [3:0]          cnt_q;
	logic [3:0]          cnt_d;
	logic                ack_seen_q;
	logic                ack_seen_d;
	logic                rw_q;
	logic                rw_d;
	logic                ctl_phase_q;
	logic                ctl_phase_d;
	logic                co_q;
	logic                co_d;
	logic                sel_q;
	logic                sel_d;
	logic                oe_q;
	logic                oe_d;
	logic [7:0]          tx_q;
	logic [7:0]          tx_d;
	logic [lcd_twi_pkg::PTR_W-1:0] ptr_q;
	logic [lcd_twi_pkg::PTR_W-1:0] ptr_d;
	lcd_twi_pkg::cmd_s    cmd_q;
	lcd_twi_pkg::cmd_s    cmd_d;
	lcd_twi_pkg::ram_wr_s wr_q;
	lcd_twi_pkg::ram_wr_s wr_d;
	logic                busy_q;
	logic                busy_d;

	always_comb begin
		st_d        = st_q;
		sh_d        = sh_q;
		cnt_d       = cnt_q;
		ack_seen_d  = ack_seen_q;
		rw_d        = rw_q;
		ctl_phase_d = ctl_phase_q;
		co_d        = co_q;
		sel_d       = sel_q;
		oe_d        = oe_q;
		tx_d        = tx_q;
		ptr_d       = ptr_q;
		cmd_d       = cmd_q;
		wr_d        = wr_q;
		cmd_d.valid = 1'b0;
		wr_d.valid  = 1'b0;
		if (i_ptr_load) begin
			ptr_d = i_ptr_value;
		end
		if (start_ev) begin
			// covers repeated start too
			st_d        = lcd_twi_pkg::ST_ADDR;
			cnt_d       = 4'h0;
			ctl_phase_d = 1'b1;
			ack_seen_d  = 1'b0;
			oe_d        = 1'b0;
		end else if (stop_ev) begin
			st_d        = lcd_twi_pkg::ST_IDLE;
			cnt_d       = 4'h0;
			ctl_phase_d = 1'b1;
			oe_d        = 1'b0;
		end else begin
			case (st_q)
				lcd_twi_pkg::ST_ADDR: begin
					if (rise_ev) begin
						sh_d  = {sh_q[6:0], bit_sync_q};
						cnt_d = cnt_q + 4'h1;
					end else if (fall_ev && cnt_q == lcd_twi_pkg::BYTE_BITS) begin
						if (sh_q[7:1] == own_addr) begin
							rw_d       = sh_q[0];
							oe_d       = 1'b1;
							ack_seen_d = 1'b0;
							st_d       = lcd_twi_pkg::ST_ADDR_ACK;
						end else begin
							st_d = lcd_twi_pkg::ST_IGNORE;
						end
					end
				end
				lcd_twi_pkg::ST_ADDR_ACK: begin
					if (rise_ev) begin
						ack_seen_d = 1'b1;
					end else if (fall_ev && ack_seen_q) begin
						cnt_d = 4'h0;
						if (rw_q && !sel_q) begin
							// first read bit goes out right after the acknowledge
							tx_d = i_rd_data;
							oe_d = ~i_rd_data[7];
							st_d = lcd_twi_pkg::ST_TX;
						end else if (rw_q) begin
							// nothing to send after a ram select: bus reads high
							oe_d = 1'b0;
							st_d = lcd_twi_pkg::ST_IGNORE;
						end else begin
							oe_d = 1'b0;
							st_d = lcd_twi_pkg::ST_RX;
						end
					end
				end
				lcd_twi_pkg::ST_RX: begin
					if (rise_ev) begin
						sh_d  = {sh_q[6:0], bit_sync_q};
						cnt_d = cnt_q + 4'h1;
					end else if (fall_ev && cnt_q == lcd_twi_pkg::BYTE_BITS) begin
						oe_d       = 1'b1;
						ack_seen_d = 1'b0;
						st_d       = lcd_twi_pkg::ST_RX_ACK;
						if (ctl_phase_q) begin
							co_d        = sh_q[lcd_twi_pkg::CO_BIT];
							sel_d       = sh_q[lcd_twi_pkg::SEL_BIT];
							ctl_phase_d = 1'b0;
						end else begin
							if (sel_q) begin
								wr_d.valid = 1'b1;
								wr_d.addr  = ptr_d;
								wr_d.data  = sh_q;
								ptr_d      = ptr_d + lcd_twi_pkg::PTR_W'(1);
							end else begin
								cmd_d.valid = 1'b1;
								cmd_d.data  = sh_q;
							end
							ctl_phase_d = co_q;
						end
					end
				end
				lcd_twi_pkg::ST_RX_ACK: begin
					if (rise_ev) begin
						ack_seen_d = 1'b1;
					end else if (fall_ev && ack_seen_q) begin
						oe_d  = 1'b0;
						cnt_d = 4'h0;
						st_d  = lcd_twi_pkg::ST_RX;
					end
				end
				lcd_twi_pkg::ST_TX: begin
					if (rise_ev) begin
						cnt_d = cnt_q + 4'h1;
					end else if (fall_ev) begin
						if (cnt_q == lcd_twi_pkg::BYTE_BITS) begin
							oe_d       = 1'b0;
							ack_seen_d = 1'b0;
							st_d       = lcd_twi_pkg::ST_TX_ACK;
						end else begin
							tx_d = {tx_q[6:0], 1'b1};
							oe_d = ~tx_q[6];
						end
					end
				end
				lcd_twi_pkg::ST_TX_ACK: begin
					if (rise_ev) begin
						if (bit_sync_q) begin
							st_d = lcd_twi_pkg::ST_IGNORE;
						end else begin
							ack_seen_d = 1'b1;
						end
					end else if (fall_ev && ack_seen_q) begin
						tx_d  = i_rd_data;
						oe_d  = ~i_rd_data[7];
						cnt_d = 4'h0;
						st_d  = lcd_twi_pkg::ST_TX;
					end
				end
				lcd_twi_pkg::ST_IGNORE: begin
					oe_d = 1'b0;
				end
				default: begin
					oe_d = 1'b0;
				end
			endcase
		end
		busy_d = (st_d != lcd_twi_pkg::ST_IDLE);
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q        <= lcd_twi_pkg::ST_IDLE;
			sh_q        <= 8'h00;
			cnt_q       <= 4'h0;
			ack_seen_q  <= 1'b0;
			rw_q        <= 1'b0;
			ctl_phase_q <= 1'b1;
			co_q        <= 1'b0;
			sel_q       <= lcd_twi_pkg::SEL_RST;
			oe_q        <= 1'b0;
			tx_q        <= 8'hFF;
			ptr_q       <= lcd_twi_pkg::PTR_RST;
			cmd_q       <= '0;
			wr_q        <= '0;
			busy_q      <= 1'b0;
		end else begin
			st_q        <= st_d;
			sh_q        <= sh_d;
			cnt_q       <= cnt_d;
			ack_seen_q  <= ack_seen_d;
			rw_q        <= rw_d;
			ctl_phase_q <= ctl_phase_d;
			co_q        <= co_d;
			sel_q       <= sel_d;
			oe_q        <= oe_d;
			tx_q        <= tx_d;
			ptr_q       <= ptr_d;
			cmd_q       <= cmd_d;
			wr_q        <= wr_d;
			busy_q      <= busy_d;
		end
	end

	// ==========================================================
	// outputs
	// open-drain: the data level is always low, only the enable moves
	assign o_sda_o  = sel_sync_q;
	assign o_sda_oe = oe_q;
	assign o_cmd    = cmd_q;
	assign o_ram_wr = wr_q;
	assign o_busy   = busy_q;
endmodule

// File: rtl/line_filter.sv
// two-flop synchroniser followed by a spike-rejecting stability filter
`timescale 1ns/1ps
module line_filter #(
	parameter int STABLE_CYC = 3,
	parameter bit RST_VAL    = 1'b1
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_line,
	output logic      o_line
);
	localparam int CW = $clog2(STABLE_CYC + 1);

	// refused at elaboration: a zero count would let spikes straight through
	if (STABLE_CYC < 1) begin
		$error("line_filter needs at least one stable cycle");
	end

	logic          meta_q;
	logic          sync_q;
	logic          out_q;
	logic          out_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// ==========================================================
	// filter
	always_comb begin
		out_d = out_q;
		cnt_d = '0;
		if (sync_q != out_q) begin
			cnt_d = cnt_q + CW'(1);
			if (cnt_q == CW'(STABLE_CYC - 1)) begin
				out_d = sync_q;
				cnt_d = '0;
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
			out_q  <= RST_VAL;
			cnt_q  <= '0;
		end else begin
			meta_q <= i_line;
			sync_q <= meta_q;
			out_q  <= out_d;
			cnt_q  <= cnt_d;
		end
	end

	assign o_line = out_q;
endmodule

// File: testbench/lcd_twi_port_props.sv
// assertion checker for the two-wire display command port
`timescale 1ns/1ps
module lcd_twi_port_props (
	input wire logic                 i_core_clk,
	input wire logic                 i_rst,
	input wire logic                 i_scl,
	input wire logic                 i_sda,
	input wire logic                 o_sda_o,
	input wire logic                 o_sda_oe,
	input wire logic                 i_ptr_load,
	input wire lcd_twi_pkg::cmd_s    o_cmd,
	input wire lcd_twi_pkg::ram_wr_s o_ram_wr,
	input wire logic                 o_busy
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// ==========
	// last written address; a pointer load breaks the chain
	logic [lcd_twi_pkg::PTR_W-1:0] last_q, last_d;
	logic                          seen_q, seen_d;
	always_comb begin
		last_d = last_q;
		seen_d = seen_q;
		if (o_ram_wr.valid) begin
			last_d = o_ram_wr.addr;
			seen_d = 1'b1;
		end
		if (i_ptr_load) begin
			seen_d = 1'b0;
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			last_q <= '0;
			seen_q <= 1'b0;
		end else begin
			last_q <= last_d;
			seen_q <= seen_d;
		end
	end
	// ==========
	// properties
	sequence s_start; $fell(i_sda) && i_scl ##1 (!i_sda && i_scl) [*4]; endsequence
	sequence s_stop; $rose(i_sda) && i_scl ##1 (i_sda && i_scl) [*4]; endsequence
	sequence s_spike; !o_busy && i_scl && $fell(i_sda) ##[1:2] $rose(i_sda); endsequence
	chk_busy_start: assert property (s_start |-> ##[1:8] o_busy)
		else $error("busy not raised after start");
	chk_busy_stop: assert property (s_stop |-> ##[1:8] !o_busy)
		else $error("busy not dropped after stop");
	chk_spike_ignored: assert property (s_spike |-> ##1 !o_busy [*8])
		else $error("short pulse taken as start");
	chk_idle_release: assert property (!o_busy |-> !o_sda_oe)
		else $error("sda driven while idle");
	chk_sda_stable_high: assert property (o_sda_oe && i_scl |=> o_sda_oe || !i_scl)
		else $error("sda drive changed while scl high");
	chk_data_with_ack: assert property (
		o_ram_wr.valid || o_cmd.valid |-> $rose(o_sda_oe) && !o_sda_o)
		else $error("byte delivered without acknowledge");
	chk_route_one_way: assert property (!(o_ram_wr.valid && o_cmd.valid))
		else $error("byte sent to ram and decoder");
	chk_ptr_step: assert property (
		o_ram_wr.valid && seen_q && !i_ptr_load |-> o_ram_wr.addr == last_q + 1'b1)
		else $error("ram pointer did not step by one");
endmodule
bind lcd_twi_port lcd_twi_port_props lcd_twi_port_props_inst (.i_core_clk, .i_rst, .i_scl,
	.i_sda, .o_sda_o, .o_sda_oe, .i_ptr_load, .o_cmd, .o_ram_wr, .o_busy);

// File: testbench/lcd_two_wire_command_port_test.sv
// self-checking bench for the two-wire display command port
`timescale 1ns/1ps
module lcd_two_wire_command_port_test;
	logic                          clk = 1'b0;
	logic                          link_clk = 1'b0;
	logic                          rst = 1'b1;
	logic                          sel_lo = 1'b0;
	logic                          sel_hi = 1'b0;
	logic                          ptr_load = 1'b0;
	logic [lcd_twi_pkg::PTR_W-1:0] ptr_value = '0;
	logic [7:0]                    rd_data = 8'h00;
	logic                          scl, m_low, sda, sda_o, sda_oe, busy;
	lcd_twi_pkg::cmd_s             cmd;
	lcd_twi_pkg::ram_wr_s          ram_wr;
	logic [17:0]                   wq[$];
	logic [17:0]                   cq[$];
	int                            fail_count = 0;
	int                            comparisons = 0;
	always #12.5 clk = ~clk;
	always #40 link_clk = ~link_clk;
	// open drain with pull-up
	assign sda = !(m_low || (sda_oe && !sda_o));
	lcd_twi_port lcd_twi_port_inst (.i_core_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_addr_select_lo(sel_lo),
		.i_addr_select_hi(sel_hi), .i_ptr_load(ptr_load), .i_ptr_value(ptr_value),
		.i_rd_data(rd_data), .o_cmd(cmd), .o_ram_wr(ram_wr), .o_busy(busy));
	twi_master_model twi_master_model_inst (.i_link_clk(link_clk), .i_sda(sda), .o_scl(scl),
		.o_sda_low(m_low));
	always @(posedge clk) begin
		if (ram_wr.valid === 1'b1) wq.push_back({ram_wr.addr, ram_wr.data});
		if (cmd.valid === 1'b1) cq.push_back(18'(cmd.data));
	end
	// ==========
	// checking helpers
	task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
		end
	endtask
	task automatic check_q(input string what, ref logic [17:0] q[$], input logic [17:0] e[$]);
		check(what, 18'(q.size()), 18'(e.size()));
		foreach (e[i]) if (i < q.size()) check(what, q[i], e[i]);
		q.delete();
	endtask
	task automatic wr(input logic [7:0] d, input logic exp_ack);
		logic [7:0] r;
		logic       a;
		twi_master_model_inst.xfer(d, 1'b1, r, a);
		check("ack", 18'(!a), 18'(exp_ack));
	endtask
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) wr(b[i], 1'b1);
	endtask
	task automatic open_xfer(input logic rw);
		twi_master_model_inst.start();
		wr({lcd_twi_pkg::ADDR_BASE, sel_hi, sel_lo, rw}, 1'b1);
	endtask
	// ==========
	// scenarios
	task automatic s_addr();
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			sel_hi <= k[1];
			sel_lo <= k[0];
			repeat (4) @(posedge clk);
			twi_master_model_inst.start();
			wr({lcd_twi_pkg::ADDR_BASE, ~k[1], ~k[0], 1'b0}, 1'b0);
			wr(8'h40, 1'b0);
			open_xfer(1'b0);
			twi_master_model_inst.stop();
		end
		check("ram count", 18'(wq.size()), 18'h0);
	endtask
	task automatic s_stream();
		logic [7:0] r;
		logic       a;
		@(posedge clk);
		ptr_value <= 10'h05E;
		ptr_load <= 1'b1;
		@(posedge clk);
		ptr_load <= 1'b0;
		open_xfer(1'b0);
		send('{8'h40, 8'hC0, 8'h80, 8'h00});
		twi_master_model_inst.stop();
		check_q("ram", wq, '{{10'h05E, 8'hC0}, {10'h05F, 8'h80}, {10'h060, 8'h00}});
		check("cmd count", 18'(cq.size()), 18'h0);
		// last select was ram data: nothing is sent, the line stays released
		open_xfer(1'b1);
		twi_master_model_inst.xfer(8'hFF, 1'b1, r, a);
		twi_master_model_inst.stop();
		check("read byte", 18'(r), 18'hFF);
	endtask
	task automatic s_words();
		open_xfer(1'b0);
		send('{8'h80, 8'hA5, 8'hC0, 8'h3C, 8'h00, 8'hC1, 8'h5A});
		twi_master_model_inst.stop();
		check_q("cmd", cq, '{18'hA5, 18'hC1, 18'h5A});
		check_q("ram", wq, '{{10'h061, 8'h3C}});
	endtask
	task automatic s_read();
		logic [7:0] r;
		logic       a;
		@(posedge clk);
		rd_data <= 8'h16;
		open_xfer(1'b1);
		twi_master_model_inst.xfer(8'hFF, 1'b0, r, a);
		check("read byte", 18'(r), 18'h16);
		// new byte before the ack fall fetches it; msb low so a missed nack would drive
		@(posedge clk);
		rd_data <= 8'h5A;
		twi_master_model_inst.xfer(8'hFF, 1'b1, r, a);
		check("read byte", 18'(r), 18'h5A);
		twi_master_model_inst.tick(3);
		check("sda drive", 18'(sda_oe), 18'h0);
		twi_master_model_inst.stop();
	endtask
	task automatic s_restart();
		logic s;
		twi_master_model_inst.spike();
		repeat (20) @(posedge clk);
		check("busy", 18'(busy), 18'h0);
		open_xfer(1'b0);
		wr(8'h40, 1'b1);
		// half a byte, then a repeated start cuts it off
		repeat (4) twi_master_model_inst.bit_io(1'b1, s);
		open_xfer(1'b0);
		send('{8'h80, 8'h77});
		twi_master_model_inst.stop();
		repeat (10) @(posedge clk);
		check("busy", 18'(busy), 18'h0);
		check_q("cmd", cq, '{18'h77});
		check("ram count", 18'(wq.size()), 18'h0);
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#1000000;
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		s_addr();
		s_stream();
		s_words();
		s_read();
		s_restart();
		finish_test();
	end
endmodule

// File: testbench/twi_master_model.sv
// behavioural two-wire bus master on the far side of the port
`timescale 1ns/1ps
module twi_master_model (
	input  wire logic i_link_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_link_clk);
	endtask
	// data moves mid low phase, well after the device lets go
	task automatic bit_io(input logic b, output logic s);
		tick(3);
		o_sda_low <= !b;
		tick(3);
		o_scl <= 1'b1;
		tick(2);
		s = i_sda;
		tick(2);
		o_scl <= 1'b0;
	endtask
	task automatic start();
		tick(3);
		o_sda_low <= 1'b0;
		tick(3);
		o_scl <= 1'b1;
		tick(4);
		o_sda_low <= 1'b1;
		tick(4);
		o_scl <= 1'b0;
	endtask
	task automatic stop();
		tick(3);
		o_sda_low <= 1'b1;
		tick(3);
		o_scl <= 1'b1;
		tick(4);
		o_sda_low <= 1'b0;
		tick(4);
	endtask
	// sending all ones leaves sda to the device when reading
	task automatic xfer(input logic [7:0] tx, input logic nack,
		output logic [7:0] rx, output logic ack_n);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(nack, ack_n);
	endtask
	task automatic spike();
		@(posedge i_link_clk);
		o_sda_low <= 1'b1;
		#50 o_sda_low <= 1'b0;
	endtask
endmodule
